/* File: hdl/acl_regs.v */
// Configuration, calibration and map-lock register bank with map checksum
// Functional notes
// - Two soft-reset bits, one per channel, 1 holds channel in reset, reset 0.
// - Two shutdown bits, one per channel, 1 powers channel down, reset 0.
// - External reference select 1 disables internal reference; 0 enables it.
// - External clock select resets 1; 1 disables crystal, 0 enables it.
// - Unused configuration bits read zero and ignore writes.
// - Offset enabled adds signed 24-bit offset to raw channel code.
// - Offset values ignored when disabled but not cleared.
// - Gain enabled multiplies corrected code by gain plus one, LSB 2^-23.
// - Gain is signed fraction; multiplier spans zero to just under two.
// - Gain values ignored when disabled but preserved.
// - Lock equal password: all writable, checksum zero, interrupt clear, no calc.
// - Lock field resets to password, map starts unlocked.
// - Lock not password: only lock register writable.
// - Locked: checksum computed continuously, interrupt raised if enabled.
// - Checksum is read-only, updated every 12 master clock periods.
// - Checksum is CRC-16 over the configuration, offset and gain register contents, not the lock register.
// - Gain correction delays results and ready pulses by 24 clocks.
// - Offset correction, reset disabled, adds no latency.
`timescale 1ns/10ps
`include "acl_defs.vh"
module acl_regs #(
	parameter W = 24
) (
	input  wire              core_clk_i,
	input  wire              rst_i,
	input  wire              reg_wr_i,
	input  wire              reg_rd_i,
	input  wire [4:0]        reg_addr_i,
	input  wire [W-1:0]      reg_wdata_i,
	output reg  [W-1:0]      reg_rdata_o,
	output wire              reg_wr_refused_o,
	input  wire              offset_correction_enable_i,
	input  wire              gain_correction_enable_i,
	input  wire              crc_int_enable_i,
	input  wire [1:0]        raw_valid_i,
	input  wire [2*W-1:0]    raw_code_i,
	output wire [1:0]        res_valid_o,
	output wire [2*W-1:0]    res_code_o,
	output wire [1:0]        channel_soft_reset_o,
	output wire [1:0]        channel_shutdown_o,
	output wire              internal_reference_enable_o,
	output wire              crystal_oscillator_enable_o,
	output wire              external_clock_select_o,
	output wire              map_locked_o,
	output reg               crc_int_o,
	output wire [15:0]       map_checksum_o
);
	localparam NREG = 5;
	localparam NBIT = NREG * W;

	reg  [W-1:0]  cfg_reg;
	reg  [W-1:0]  off_reg  [0:1];
	reg  [W-1:0]  gain_reg [0:1];
	reg  [7:0]    lock_reg;
	reg  [15:0]   crc_reg;
	reg  [15:0]   crc_acc_reg;
	reg  [6:0]    bit_cnt_reg;
	reg  [3:0]    tick_cnt_reg;
	reg  [15:0]   crc_last_reg;
	wire          unlocked;
	wire          wr_lock;
	wire [NBIT-1:0] image;
	wire          msg_bit;
	wire          fb;
	wire          scan_done;

	// Address decode used for writes and reads
	function [2:0] sel_of;
		input [4:0] a;
		begin
			if (a == `ACL_ADDR_CFG)
				sel_of = 3'h0;
			else if (a == `ACL_ADDR_OFF0)
				sel_of = 3'h1;
			else if (a == `ACL_ADDR_GAIN0)
				sel_of = 3'h2;
			else if (a == `ACL_ADDR_OFF1)
				sel_of = 3'h3;
			else if (a == `ACL_ADDR_GAIN1)
				sel_of = 3'h4;
			else if (a == `ACL_ADDR_LOCK)
				sel_of = 3'h5;
			else
				sel_of = 3'h7;
		end
	endfunction

	assign unlocked = (lock_reg == `ACL_PASSWORD);
	assign wr_lock  = reg_wr_i && (sel_of(reg_addr_i) == 3'h5);
	// Writes to map registers while locked are dropped
	assign reg_wr_refused_o = reg_wr_i && !unlocked && (sel_of(reg_addr_i) <= 3'h4);

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_reg     <= `ACL_CFG_RESET;
			off_reg[0]  <= {W{1'b0}};
			off_reg[1]  <= {W{1'b0}};
			gain_reg[0] <= {W{1'b0}};
			gain_reg[1] <= {W{1'b0}};
			lock_reg    <= `ACL_PASSWORD;
		end else begin
			if (wr_lock)
				lock_reg <= reg_wdata_i[23:16];
			if (reg_wr_i && unlocked) begin
				if (sel_of(reg_addr_i) == 3'h0)
					cfg_reg <= reg_wdata_i & `ACL_CFG_WMASK;
				else if (sel_of(reg_addr_i) == 3'h1)
					off_reg[0] <= reg_wdata_i;
				else if (sel_of(reg_addr_i) == 3'h2)
					gain_reg[0] <= reg_wdata_i;
				else if (sel_of(reg_addr_i) == 3'h3)
					off_reg[1] <= reg_wdata_i;
				else if (sel_of(reg_addr_i) == 3'h4)
					gain_reg[1] <= reg_wdata_i;
			end
		end
	end

	// Read data, registered; unmapped reads zero
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= {W{1'b0}};
		end else if (reg_rd_i) begin
			if (sel_of(reg_addr_i) == 3'h0)
				reg_rdata_o <= cfg_reg;
			else if (sel_of(reg_addr_i) == 3'h1)
				reg_rdata_o <= off_reg[0];
			else if (sel_of(reg_addr_i) == 3'h2)
				reg_rdata_o <= gain_reg[0];
			else if (sel_of(reg_addr_i) == 3'h3)
				reg_rdata_o <= off_reg[1];
			else if (sel_of(reg_addr_i) == 3'h4)
				reg_rdata_o <= gain_reg[1];
			else if (sel_of(reg_addr_i) == 3'h5)
				reg_rdata_o <= {lock_reg, crc_reg};
			else
				reg_rdata_o <= {W{1'b0}};
		end
	end

	assign channel_soft_reset_o        = cfg_reg[`ACL_SRST_LSB+1:`ACL_SRST_LSB];
	assign channel_shutdown_o          = cfg_reg[`ACL_SHDN_LSB+1:`ACL_SHDN_LSB];
	assign internal_reference_enable_o = ~cfg_reg[`ACL_EXTERNAL_REFERENCE_SELECT_BIT];
	assign external_clock_select_o     = cfg_reg[`ACL_EXTERNAL_CLOCK_SELECT_BIT];
	assign crystal_oscillator_enable_o = ~cfg_reg[`ACL_EXTERNAL_CLOCK_SELECT_BIT];
	assign map_locked_o                = ~unlocked;

	// Message image: lowest address in the top bits, scanned MSB first
	assign image   = {cfg_reg, off_reg[0], gain_reg[0], off_reg[1], gain_reg[1]};
	assign msg_bit = image[NBIT-1-bit_cnt_reg];
	assign fb      = msg_bit ^ crc_acc_reg[15];
	assign scan_done = (bit_cnt_reg == NBIT[6:0] - 7'd1);

	// Serial CRC walk over the image, one bit per clock
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			crc_acc_reg  <= `ACL_CRC_INIT;
			bit_cnt_reg  <= 7'd0;
			crc_last_reg <= 16'h0000;
		end else if (unlocked) begin
			crc_acc_reg  <= `ACL_CRC_INIT;
			bit_cnt_reg  <= 7'd0;
			crc_last_reg <= 16'h0000;
		end else begin
			crc_acc_reg <= {crc_acc_reg[14:0], 1'b0} ^ (fb ? `ACL_CRC_POLY : 16'h0000);
			if (scan_done) begin
				bit_cnt_reg  <= 7'd0;
				crc_last_reg <= {crc_acc_reg[14:0], 1'b0} ^ (fb ? `ACL_CRC_POLY : 16'h0000);
				crc_acc_reg  <= `ACL_CRC_INIT;
			end else begin
				bit_cnt_reg <= bit_cnt_reg + 7'd1;
			end
		end
	end

	// Visible checksum refreshed every period of master clocks
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_reg <= 4'h0;
			crc_reg      <= 16'h0000;
			crc_int_o    <= 1'b0;
		end else if (unlocked) begin
			tick_cnt_reg <= 4'h0;
			crc_reg      <= 16'h0000;
			crc_int_o    <= 1'b0;
		end else begin
			if (tick_cnt_reg == 4'd`ACL_CRC_PERIOD - 4'd1) begin
				tick_cnt_reg <= 4'h0;
				crc_reg      <= crc_last_reg;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 4'h1;
			end
			crc_int_o <= crc_int_enable_i;
		end
	end
	assign map_checksum_o = crc_reg;

	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_ch
			acl_corr #(
				.W   (W),
				.LAT (`ACL_GAIN_LATENCY)
			) u_corr (
				.core_clk_i  (core_clk_i),
				.rst_i       (rst_i | cfg_reg[`ACL_SRST_LSB+c]),
				.raw_valid_i (raw_valid_i[c] & ~cfg_reg[`ACL_SHDN_LSB+c]),
				.raw_code_i  (raw_code_i[c*W +: W]),
				.off_en_i    (offset_correction_enable_i),
				.gain_en_i   (gain_correction_enable_i),
				.off_val_i   (off_reg[c]),
				.gain_val_i  (gain_reg[c]),
				.res_valid_o (res_valid_o[c]),
				.res_code_o  (res_code_o[c*W +: W])
			);
		end
	endgenerate
endmodule // acl_regs

/* File: hdl/acl_defs.vh */
// Register offsets, field positions, reset values and timing counts for the config/lock bank
`ifndef ACL_DEFS_VH
`define ACL_DEFS_VH
`define ACL_ADDR_CFG        5'h0E
`define ACL_ADDR_OFF0       5'h0F
`define ACL_ADDR_GAIN0      5'h10
`define ACL_ADDR_OFF1       5'h11
`define ACL_ADDR_GAIN1      5'h12
`define ACL_ADDR_LOCK       5'h1F
`define ACL_SRST_LSB        16
`define ACL_SHDN_LSB        8
`define ACL_EXTERNAL_REFERENCE_SELECT_BIT     7
`define ACL_EXTERNAL_CLOCK_SELECT_BIT      6
`define ACL_CFG_WMASK       24'h0303C0
`define ACL_CFG_RESET       24'h000040
`define ACL_PASSWORD        8'hA5
`define ACL_CRC_PERIOD      12
`define ACL_GAIN_LATENCY    24
`define ACL_CRC_POLY        16'h8005
`define ACL_CRC_INIT        16'h0000
`endif

/* File: hdl/acl_corr.v */
// Per-channel offset and gain correction datapath
`timescale 1ns/10ps
`include "acl_defs.vh"
module acl_corr #(
	parameter W   = 24,
	parameter LAT = `ACL_GAIN_LATENCY
) (
	input  wire              core_clk_i,
	input  wire              rst_i,
	input  wire              raw_valid_i,
	input  wire [W-1:0]      raw_code_i,
	input  wire              off_en_i,
	input  wire              gain_en_i,
	input  wire [W-1:0]      off_val_i,
	input  wire [W-1:0]      gain_val_i,
	output reg               res_valid_o,
	output reg  [W-1:0]      res_code_o
);
	wire signed [W-1:0]   off_code;
	wire signed [W+1:0]   mult;
	wire signed [2*W+1:0] prod;
	wire signed [W-1:0]   gain_code;
	reg         [W-1:0]   dly_code [0:LAT-1];
	reg         [LAT-1:0] dly_vld;
	integer               i;

	// Offset is combinational, no latency added
	assign off_code  = off_en_i ? $signed(raw_code_i + off_val_i) : $signed(raw_code_i);
	// Multiplier is gain+1 with 2^-23 weight: 0 .. just under 2
	assign mult      = {{2{gain_val_i[W-1]}}, gain_val_i} + {2'b01, {W{1'b0}}} - {2'b00, 1'b1, {(W-1){1'b0}}};
	assign prod      = off_code * mult;
	assign gain_code = prod[2*W-2:W-1];

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dly_vld <= {LAT{1'b0}};
			for (i = 0; i < LAT; i = i + 1)
				dly_code[i] <= {W{1'b0}};
		end else begin
			dly_vld     <= {dly_vld[LAT-2:0], raw_valid_i};
			dly_code[0] <= gain_code;
			for (i = 1; i < LAT; i = i + 1)
				dly_code[i] <= dly_code[i-1];
		end
	end

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			res_valid_o <= 1'b0;
			res_code_o  <= {W{1'b0}};
		end else if (gain_en_i) begin
			// Gain path delays results and ready pulses
			res_valid_o <= dly_vld[LAT-1];
			res_code_o  <= dly_code[LAT-1];
		end else begin
			res_valid_o <= raw_valid_i;
			res_code_o  <= off_code;
		end
	end
endmodule // acl_corr

/* File: verification/acl_checker.sv */
// Port-level assertions for the config/lock register bank
`timescale 1ns/10ps
module acl_checker (
	input wire        core_clk_i,
	input wire        rst_i,
	input wire        reg_wr_i,
	input wire [4:0]  reg_addr_i,
	input wire [23:0] reg_wdata_i,
	input wire        reg_wr_refused_o,
	input wire        gain_correction_enable_i,
	input wire        crc_int_enable_i,
	input wire [1:0]  raw_valid_i,
	input wire [1:0]  res_valid_o,
	input wire [1:0]  channel_soft_reset_o,
	input wire [1:0]  channel_shutdown_o,
	input wire        internal_reference_enable_o,
	input wire        external_clock_select_o,
	input wire        map_locked_o,
	input wire        crc_int_o,
	input wire [15:0] map_checksum_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire cal = reg_addr_i >= 5'h0E && reg_addr_i <= 5'h12;
	wire ch0 = !channel_shutdown_o[0] && !channel_soft_reset_o[0];
	wire cw  = reg_wr_i && !map_locked_o && reg_addr_i == 5'h0E;
	a_refuse_locked: assert property (reg_wr_i && map_locked_o && cal |-> reg_wr_refused_o)
		else $error("locked write not refused");
	a_cfg_write: assert property (cw |=> {channel_soft_reset_o, channel_shutdown_o} ==
		{$past(reg_wdata_i[17:16]), $past(reg_wdata_i[9:8])})
		else $error("config channel bits wrong");
	a_ref_clk_sel: assert property (cw |=> internal_reference_enable_o != $past(reg_wdata_i[7])
		&& external_clock_select_o == $past(reg_wdata_i[6]))
		else $error("reference or clock select wrong");
	a_lock_write: assert property (reg_wr_i && reg_addr_i == 5'h1F |=>
		map_locked_o == ($past(reg_wdata_i[23:16]) != 8'hA5))
		else $error("lock state wrong");
	a_unlocked_zero: assert property (!map_locked_o && $past(!map_locked_o) |->
		map_checksum_o == 16'h0000 && !crc_int_o)
		else $error("checksum or interrupt not clear");
	a_int_level: assert property (map_locked_o && $past(map_locked_o) |->
		crc_int_o == $past(crc_int_enable_i))
		else $error("checksum interrupt wrong");
	a_csum_hold: assert property (map_locked_o && $changed(map_checksum_o) |=>
		($stable(map_checksum_o) || !map_locked_o)[*8])
		else $error("checksum updated too often");
	a_gain_delay: assert property (raw_valid_i[0] && gain_correction_enable_i && ch0 |->
		!res_valid_o[0] ##25 res_valid_o[0])
		else $error("gain result latency wrong");
	a_offset_nolat: assert property (raw_valid_i[0] && !gain_correction_enable_i && ch0 |=>
		res_valid_o[0])
		else $error("result latency wrong");
endmodule // acl_checker

/* File: verification/acl_host.sv */
// Host model issuing register writes and reads
`timescale 1ns/10ps
module acl_host (
	input  wire        core_clk_i,
	input  wire [23:0] reg_rdata_i,
	output reg         reg_wr_o = 1'h0,
	output reg         reg_rd_o = 1'h0,
	output reg  [4:0]  reg_addr_o = 5'h00,
	output reg  [23:0] reg_wdata_o = 24'h000000
);
	task wr(input [4:0] a, input [23:0] v);
		begin
			@(posedge core_clk_i);
			reg_wr_o    <= 1'h1;
			reg_addr_o  <= a;
			reg_wdata_o <= v;
			@(posedge core_clk_i);
			reg_wr_o    <= 1'h0;
			reg_addr_o  <= ~a;
			reg_wdata_o <= ~v;
		end
	endtask
	task rd(input [4:0] a, output [23:0] v);
		begin
			@(posedge core_clk_i);
			reg_rd_o   <= 1'h1;
			reg_addr_o <= a;
			@(posedge core_clk_i);
			reg_rd_o   <= 1'h0;
			reg_addr_o <= ~a;
			#1 v = reg_rdata_i;
		end
	endtask
endmodule // acl_host

/* File: verification/tb_acl_regs.sv */
// Self-checking bench for the config/lock register bank
`timescale 1ns/10ps
module tb_acl_regs;
	reg         core_clk_i = 1'h0;
	reg         rst_i = 1'h1;
	reg         off_en = 1'h0;
	reg         gain_en = 1'h0;
	reg         int_en = 1'h0;
	reg  [1:0]  raw_v = 2'h0;
	reg  [47:0] raw = {24'h000001, 24'h000100};
	wire        wr, rd, refused, locked, crc_int, iref, xtal, eclk;
	wire [4:0]  addr;
	wire [23:0] wdata, rdata;
	wire [1:0]  res_v, srst, shdn;
	wire [47:0] res;
	wire [15:0] csum;
	integer     bad_count = 0, samples_checked = 0, cyc = 0, i;
	integer     ref_cnt = 0;
	reg  [52:0] rows [0:4];
	reg  [23:0] d;
	reg  [15:0] e16;
	acl_host host (.core_clk_i, .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_addr_o(addr), .reg_wdata_o(wdata));
	acl_regs uut (.core_clk_i, .rst_i, .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_wr_refused_o(refused),
		.offset_correction_enable_i(off_en), .gain_correction_enable_i(gain_en),
		.crc_int_enable_i(int_en), .raw_valid_i(raw_v), .raw_code_i(raw), .res_valid_o(res_v),
		.res_code_o(res), .channel_soft_reset_o(srst), .channel_shutdown_o(shdn),
		.internal_reference_enable_o(iref), .crystal_oscillator_enable_o(xtal),
		.external_clock_select_o(eclk), .map_locked_o(locked), .crc_int_o(crc_int),
		.map_checksum_o(csum));
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 1000) begin
			bad_count = bad_count + 1;
			test_done;
		end
	end
	always @(posedge core_clk_i) begin
		if (refused)
			ref_cnt <= ref_cnt + 1;
	end
	task test_done;
		begin
			if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [49:0] g, input [49:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	function [15:0] crc(input [119:0] m);
		integer k;
		begin
			crc = 16'h0000;
			for (k = 119; k >= 0; k = k - 1)
				crc = {crc[14:0], 1'h0} ^ ((crc[15] ^ m[k]) ? 16'h8005 : 16'h0000);
		end
	endfunction
	// Both channels pulsed; result sampled at its due cycle
	task pulse(input g, input [47:0] e);
		begin
			@(posedge core_clk_i) gain_en <= g;
			@(posedge core_clk_i) raw_v <= 2'h3;
			@(posedge core_clk_i) raw_v <= 2'h0;
			repeat (g ? 24 : 0) @(posedge core_clk_i);
			#1 chk({res_v, res}, {2'h3, e});
		end
	endtask
	initial begin
		rows[0] = {5'h0E, 24'hFFFFFF, 24'h0303C0};
		rows[1] = {5'h0F, 24'h000010, 24'h000010};
		rows[2] = {5'h10, 24'h400000, 24'h400000};
		rows[3] = {5'h11, 24'h7FFFFF, 24'h7FFFFF};
		rows[4] = {5'h12, 24'h000001, 24'h000001};
		e16 = crc({24'h0303C0, 24'h000010, 24'h400000, 24'h7FFFFF, 24'h000001});
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'h0;
		for (i = 0; i < 5; i = i + 1) begin
			host.wr(rows[i][52:48], rows[i][47:24]);
			host.rd(rows[i][52:48], d);
			chk(d, rows[i][23:0]);
		end
		@(posedge core_clk_i) int_en <= 1'h1;
		host.wr(5'h1F, 24'h000000);
		host.wr(5'h0E, 24'h000000);
		chk(locked, 1'h1);
		repeat (150) @(posedge core_clk_i);
		chk(csum, e16);
		host.rd(5'h1F, d);
		chk(d, {8'h00, e16});
		chk(crc_int, 1'h1);
		host.wr(5'h1F, 24'hA5FFFF);
		@(posedge core_clk_i);
		#1 chk({csum, crc_int, locked}, 18'h00000);
		host.rd(5'h0E, d);
		chk(d, 24'h0303C0);
		host.wr(5'h0E, 24'h000000);
		off_en <= 1'h1;
		pulse(1'h0, {24'h800000, 24'h000110});
		pulse(1'h1, {24'h7FFFFF, 24'h000198});
		@(posedge core_clk_i) off_en <= 1'h0;
		pulse(1'h0, {24'h000001, 24'h000100});
		host.rd(5'h0F, d);
		chk(d, 24'h000010);
		host.rd(5'h10, d);
		chk(d, 24'h400000);
		@(posedge core_clk_i) rst_i <= 1'h1;
		@(posedge core_clk_i) rst_i <= 1'h0;
		host.rd(5'h0E, d);
		chk(d, 24'h000040);
		chk({srst, shdn, iref, xtal, eclk}, 7'h05);
		host.rd(5'h1F, d);
		chk(d, 24'hA50000);
		chk(ref_cnt, 50'h1);
		test_done;
	end
endmodule // tb_acl_regs
bind acl_regs acl_checker chk_i (.core_clk_i, .rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_refused_o, .gain_correction_enable_i, .crc_int_enable_i, .raw_valid_i, .res_valid_o,
	.channel_soft_reset_o, .channel_shutdown_o, .internal_reference_enable_o,
	.external_clock_select_o, .map_locked_o, .crc_int_o, .map_checksum_o);
